/* dv/pfsel_asserts.sv */
// Port-level assertions for the pin function select block
`timescale 1ns/100ps
`default_nettype none
module pfsel_asserts
   import pfsel_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic [NUM_PINS-1:0] pin_in_i,
   input wire logic [NUM_PINS-1:0] pin_oe_o,
   input wire logic [NUM_PINS-1:0] pin_ana_o,
   input wire logic [NUM_PINS-1:0] gpio_di_o,
   input wire logic serial_chip_select_in_o,
   input wire logic uart1_receive_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // A request is taken only while ack is low
   wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;

   a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   a_ack_follows_req: assert property (req |=> wb_ack_o)
      else $error("request not acknowledged next cycle");
   a_no_spurious_ack: assert property (!(wb_cyc_i && wb_stb_i)
      |=> !wb_ack_o)
      else $error("ack without a request");
   a_rdata_upper_zero: assert property (wb_ack_o
      |-> wb_dat_o[31:8] == 24'h000000)
      else $error("read data upper bits not zero");
   a_analog_undriven: assert property ((pin_ana_o & pin_oe_o) == '0)
      else $error("pin driven while handed to analog");
   a_reset_all_gpio: assert property ($fell(rst_i) |-> pin_oe_o == '0 &&
      pin_ana_o == '0 && uart1_receive_o && serial_chip_select_in_o)
      else $error("outputs not idle after reset");
   a_pf6_analog_write: assert property (req && wb_we_i && wb_sel_i[0] &&
      wb_adr_i == OFS_PF_SEL_HIGH && wb_dat_i[5:4] == 2'h2
      |-> ##2 pin_ana_o[PIN_PF6])
      else $error("comparator input not routed after write");
   a_pin_level_delay: assert property (gpio_di_o == $past(pin_in_i, 3))
      else $error("synchronised pin level wrong");
endmodule
`default_nettype wire

/* dv/tb_top.sv */
// Self-checking testbench for the pin function select block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import pfsel_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0, pv = 1'b0, ack;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'h0;
   logic [31:0] wdat = 32'h0, dat_o;
   logic [NUM_PINS-1:0] pin_in = '0, gpo = '0, gpoe = '0;
   logic [NUM_PINS-1:0] pdo, poe, pana, gdi;
   logic sck_in, sda_in, cs_in, cap2, tck2, cap0, rx1;
   int err_total = 0;
   int checks_done = 0;
   // Expected role per pin and code: Gpio, Fn out, Bidirectional fn
   // (enable from the peripheral), Input fn, Analog, None
   string kinds [10] = '{"GGGN", "GGAA", "GGBA", "GGFA", "GGBA",
      "GGBA", "GGFA", "GIAA", "GFFA", "GGFA"};

   pfsel_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .pin_in_i(pin_in), .pin_do_o(pdo), .pin_oe_o(poe), .pin_ana_o(pana),
      .gpio_do_i(gpo), .gpio_oe_i(gpoe), .gpio_di_o(gdi),
      .serial_clock_do_i(pv), .serial_clock_oe_i(pv),
      .serial_data_do_i(pv), .serial_data_oe_i(pv),
      .serial_data_out_i(pv), .serial_chip_select_do_i(pv),
      .serial_chip_select_oe_i(pv), .serial_clock_in_o(sck_in),
      .serial_data_in_o(sda_in), .serial_chip_select_in_o(cs_in),
      .std_timer2_out_i(pv), .periodic_timer0_out_i(pv),
      .std_timer2_capture_in_o(cap2), .std_timer2_clock_in_o(tck2),
      .periodic_timer0_capture_in_o(cap0), .uart1_transmit_i(pv),
      .uart2_transmit_i(pv), .uart1_receive_o(rx1));

   initial begin
      forever #10 clk_i = ~clk_i;
   end

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Classic cycle: hold everything until ack is sampled high
   task automatic wb(input logic w, input logic [7:0] a,
      input logic [7:0] d, input logic [3:0] s, output logic [31:0] r);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= s;
      wdat <= {24'h000000, d};
      // Only the watchdog ends a wait that never sees ack
      do begin
         @(posedge clk_i);
      end while (ack !== 1'b1);
      r = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] r;
      wb(1'b1, a, d, 4'h1, r);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      logic [31:0] r;
      wb(1'b0, a, 8'h00, 4'h1, r);
      check(r, {24'h000000, e});
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_reset();
      for (int i = 0; i < 6; i++) rd_chk(8'(i * 4), 8'h00);
      check({pdo, pana, poe}, 32'h0000_0000);
      check({cs_in, rx1, sck_in, sda_in}, 32'h0000_000C);
      check({tck2, cap2, cap0, gdi}, 32'h0000_0000);
      $display("test reset values done");
   endtask

   // Unmapped and lane-disabled writes must leave the registers alone
   task automatic t_regs();
      logic [31:0] r;
      for (int i = 0; i < 5; i++) wr(8'(i * 4), 8'hA5 ^ 8'(i));
      wr(8'h14, 8'hFF);
      wb(1'b1, OFS_PE_SEL_LOW, 8'h00, 4'hE, r);
      for (int i = 0; i < 5; i++) rd_chk(8'(i * 4), 8'hA5 ^ 8'(i));
      rd_chk(8'h14, 8'h00);
      for (int i = 0; i < 5; i++) wr(8'(i * 4), 8'h00);
      $display("test register access done");
   endtask

   task automatic t_route();
      byte k;
      logic [7:0] a;
      logic fn;
      for (int p = 0; p < NUM_PINS; p++) begin
         a = {3'h0, PIN_REG[p], 2'h0};
         for (int c = 0; c < 4; c++) begin
            for (int v = 0; v < 2; v++) begin
               gpo <= {NUM_PINS{~v[0]}};
               gpoe <= '1;
               pv <= v[0];
               wr(a, 8'(c) << PIN_LSB[p]);
               repeat (3) @(posedge clk_i);
               k = kinds[p][c];
               fn = (k == "F") || (k == "B");
               check(poe[p], k == "G" || k == "F" || (fn && v[0]));
               check(pdo[p], (k == "G") ? !v[0] : (fn && v[0]));
               check(pana[p], k == "A");
            end
         end
         wr(a, 8'h00);
      end
      $display("test pin routing done");
   endtask

   // Peripheral inputs follow the pin only while routed
   task automatic t_input(input int p, input int c, input int s,
      input logic f);
      logic [7:0] a;
      logic o;
      a = {3'h0, PIN_REG[p], 2'h0};
      wr(a, 8'(c) << PIN_LSB[p]);
      for (int b = 0; b < 2; b++) begin
         pin_in <= {NUM_PINS{b[0]}};
         repeat (5) @(posedge clk_i);
         o = s == 0 ? rx1 : s == 1 ? cs_in : s == 2 ? cap2 : s == 3 ? sck_in
            : s == 4 ? sda_in : s == 5 ? tck2 : cap0;
         // Unrouted receive and chip select idle high, the rest low
         check(o, f ? b[0] : (s < 2));
         check(gdi, {NUM_PINS{b[0]}});
      end
      pin_in <= '0;
      wr(a, 8'h00);
      $display("test input path done");
   endtask

   initial begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_reset();
      t_regs();
      t_route();
      t_input(PIN_PF6, 1, 0, 1'b1);
      t_input(PIN_PF6, 0, 0, 1'b0);
      t_input(PIN_PF0, 2, 1, 1'b1);
      t_input(PIN_PF7, 0, 2, 1'b1);
      t_input(PIN_PF3, 2, 3, 1'b1);
      t_input(PIN_PF0, 0, 1, 1'b0);
      t_input(PIN_PF2, 2, 4, 1'b1);
      t_input(PIN_PF2, 3, 4, 1'b0);
      t_input(PIN_PF6, 0, 5, 1'b1);
      t_input(PIN_PF6, 1, 5, 1'b0);
      t_input(PIN_PF5, 1, 6, 1'b1);
      t_input(PIN_PF5, 2, 6, 1'b0);
      report_and_stop();
   end

   initial begin
      #400000;
      err_total++;
      report_and_stop();
   end
endmodule

bind pfsel_top pfsel_asserts i_chk (.clk_i, .rst_i, .wb_cyc_i,
   .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
   .wb_ack_o, .pin_in_i, .pin_oe_o, .pin_ana_o, .gpio_di_o,
   .serial_chip_select_in_o, .uart1_receive_o);
`default_nettype wire

/* rtl/pfsel_cell.sv */
// One pin's output path: picks port latch, peripheral or release
`timescale 1ns/100ps
`default_nettype none
module pfsel_cell
   import pfsel_pkg::*;
#(
   parameter logic [7:0] KINDS = 8'h00
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Select code
   input wire logic [1:0] code_i,
   // Port data latch side
   input wire logic gpio_do_i,
   input wire logic gpio_oe_i,
   // Peripheral side, one entry per code
   input wire logic [3:0] fn_do_i,
   input wire logic [3:0] fn_oe_i,
   // Pin side
   output logic pin_do_o,
   output logic pin_oe_o,
   output logic pin_ana_o
);
   logic [1:0] kind;

   assign kind = KINDS[2*code_i +: 2];

   // R12 - peripheral drives pin
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin_do_o <= 1'b0;
         pin_oe_o <= 1'b0;
         pin_ana_o <= 1'b0;
      end else begin
         unique case (kind)
            KIND_GPIO: begin
               pin_do_o <= gpio_do_i;
               pin_oe_o <= gpio_oe_i;
               pin_ana_o <= 1'b0;
            end
            KIND_FN: begin
               pin_do_o <= fn_do_i[code_i];
               pin_oe_o <= fn_oe_i[code_i];
               pin_ana_o <= 1'b0;
            end
            KIND_ANA: begin
               pin_do_o <= 1'b0;
               pin_oe_o <= 1'b0;
               pin_ana_o <= 1'b1;
            end
            KIND_NONE: begin
               // R2 - unimplemented code releases pin
               pin_do_o <= 1'b0;
               pin_oe_o <= 1'b0;
               pin_ana_o <= 1'b0;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

/* rtl/pfsel_pkg.sv */
// Package for the port E/F/G pin function select block
package pfsel_pkg;

   // ------------------------------------------------------------
   // Register map (byte addresses, one aligned word each)
   // ------------------------------------------------------------
   localparam int NUM_REGS = 5;
   localparam int REG_W = 8;
   localparam logic [7:0] OFS_PE_SEL_LOW = 8'h00;
   localparam logic [7:0] OFS_PE_SEL_HIGH = 8'h04;
   localparam logic [7:0] OFS_PF_SEL_LOW = 8'h08;
   localparam logic [7:0] OFS_PF_SEL_HIGH = 8'h0C;
   localparam logic [7:0] OFS_PG_SEL_LOW = 8'h10;
   localparam logic [7:0] REG_RESET = 8'h00;

   // Register indices (byte address / 4)
   localparam logic [2:0] IDX_PE_LOW = 3'h0;
   localparam logic [2:0] IDX_PE_HIGH = 3'h1;
   localparam logic [2:0] IDX_PF_LOW = 3'h2;
   localparam logic [2:0] IDX_PF_HIGH = 3'h3;
   localparam logic [2:0] IDX_PG_LOW = 3'h4;

   // ------------------------------------------------------------
   // Routed pins
   // ------------------------------------------------------------
   localparam int NUM_PINS = 10;
   localparam int PIN_PE4 = 0;
   localparam int PIN_PE5 = 1;
   localparam int PIN_PF0 = 2;
   localparam int PIN_PF1 = 3;
   localparam int PIN_PF2 = 4;
   localparam int PIN_PF3 = 5;
   localparam int PIN_PF5 = 6;
   localparam int PIN_PF6 = 7;
   localparam int PIN_PF7 = 8;
   localparam int PIN_PG1 = 9;

   // Register holding each pin's select field, listed PG1 down to PE4
   localparam logic [9:0][2:0] PIN_REG = {
      IDX_PG_LOW, IDX_PF_HIGH, IDX_PF_HIGH, IDX_PF_HIGH,
      IDX_PF_LOW, IDX_PF_LOW, IDX_PF_LOW, IDX_PF_LOW,
      IDX_PE_HIGH, IDX_PE_HIGH};
   // Low bit of each select field within its register
   localparam logic [9:0][2:0] PIN_LSB = {
      3'h2, 3'h6, 3'h4, 3'h2, 3'h6, 3'h4, 3'h2, 3'h0, 3'h2, 3'h0};

   // ------------------------------------------------------------
   // Function select codes and routing kinds
   // ------------------------------------------------------------
   localparam logic [1:0] CODE_0 = 2'h0;
   localparam logic [1:0] CODE_1 = 2'h1;
   localparam logic [1:0] CODE_2 = 2'h2;
   localparam logic [1:0] CODE_3 = 2'h3;

   localparam logic [1:0] KIND_GPIO = 2'h0;
   localparam logic [1:0] KIND_FN = 2'h1;
   localparam logic [1:0] KIND_ANA = 2'h2;
   localparam logic [1:0] KIND_NONE = 2'h3;

   // Per pin, kind of code 3..0 in bits 7:6..1:0
   localparam logic [9:0][7:0] PIN_KINDS = {
      8'h90, 8'h94, 8'hA4, 8'h90, 8'h90,
      8'h90, 8'h90, 8'h90, 8'hA0, 8'hC0};

endpackage

/* rtl/pfsel_sync.sv */
// Two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/100ps
`default_nettype none
module pfsel_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Data
   input wire logic [WIDTH-1:0] d_i,
   output logic [WIDTH-1:0] q_o
);
   logic [WIDTH-1:0] meta_q;

   // First stage feeds only the second stage
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta_q <= '0;
         q_o <= '0;
      end else begin
         meta_q <= d_i;
         q_o <= meta_q;
      end
   end
endmodule
`default_nettype wire

/* rtl/pfsel_top.sv */
// Pin function select for ports E, F and G with a Wishbone slave
//
// What this block does
// R1 - PE5: codes 00/01 GPIO, 10 LCD pump capacitor, 11 LCD segment 55.
// R2 - PE4: codes 00/01/10 GPIO; 11 selects nothing.
// R3 - PF3: 00/01 GPIO, 10 serial clock, 11 LCD segment 12.
// R4 - PF2: 00/01 GPIO, 10 serial data in or bidirectional, 11 segment 13.
// R5 - PF1: 00/01 GPIO, 10 serial data out, 11 LCD segment 14.
// R6 - PF0: 00/01 GPIO, 10 serial chip select, 11 LCD segment 15.
// R7 - PF7: 00 GPIO/timer2 capture, 01 timer2 out, 10 UART1 tx, 11 C0+.
// R8 - PF6: 00 GPIO/timer2 clock, 01 UART1 rx, 10 C0-, 11 segment 37.
// R9 - PF5: 00/01 GPIO/ptimer0 capture, 10 ptimer0 out, 11 crystal.
// R10 - PG1: 00/01 GPIO, 10 UART2 transmit, 11 LCD common 1.
// R11 - Select fields are read/write, reset to zero, act once written.
// R12 - Routed inputs see pin level; routed outputs drive pin, not latch.
`timescale 1ns/100ps
`default_nettype none
module pfsel_top
   import pfsel_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Pins (PE4, PE5, PF0..PF3, PF5..PF7, PG1)
   input wire logic [NUM_PINS-1:0] pin_in_i,
   output logic [NUM_PINS-1:0] pin_do_o,
   output logic [NUM_PINS-1:0] pin_oe_o,
   output logic [NUM_PINS-1:0] pin_ana_o,
   // Port data latch side
   input wire logic [NUM_PINS-1:0] gpio_do_i,
   input wire logic [NUM_PINS-1:0] gpio_oe_i,
   output logic [NUM_PINS-1:0] gpio_di_o,
   // Serial interface
   input wire logic serial_clock_do_i,
   input wire logic serial_clock_oe_i,
   input wire logic serial_data_do_i,
   input wire logic serial_data_oe_i,
   input wire logic serial_data_out_i,
   input wire logic serial_chip_select_do_i,
   input wire logic serial_chip_select_oe_i,
   output logic serial_clock_in_o,
   output logic serial_data_in_o,
   output logic serial_chip_select_in_o,
   // Timers
   input wire logic std_timer2_out_i,
   input wire logic periodic_timer0_out_i,
   output logic std_timer2_capture_in_o,
   output logic std_timer2_clock_in_o,
   output logic periodic_timer0_capture_in_o,
   // UARTs
   input wire logic uart1_transmit_i,
   input wire logic uart2_transmit_i,
   output logic uart1_receive_o
);

   // ------------------------------------------------------------
   // Select registers
   // ------------------------------------------------------------
   logic [NUM_REGS-1:0][REG_W-1:0] sel_reg_q;
   logic [NUM_PINS-1:0][1:0] code;
   logic [NUM_PINS-1:0] pin_sync;
   logic bus_req;
   logic addr_hit;
   logic wr_hit;
   logic rd_hit;
   logic [2:0] idx;

   assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   // Writes use byte lane 0 only; the upper lanes hold nothing here
   assign wr_hit = bus_req && wb_we_i && addr_hit && wb_sel_i[0];
   // Reads reload the data register only when a read is taken
   assign rd_hit = bus_req && !wb_we_i;
   assign idx = wb_adr_i[4:2];
   // Only word-aligned addresses inside the five-word window decode
   assign addr_hit = (wb_adr_i[7:5] == 3'h0) && (wb_adr_i[1:0] == 2'h0)
      && (idx <= IDX_PG_LOW);

   // ------------------------------------------------------------
   // Wishbone handshake
   // ------------------------------------------------------------
   // Ack one cycle after the request, then drop for one cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= bus_req;
      end
   end

   // Unmapped reads return zero; reserved upper bits read zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (rd_hit) begin
         if (addr_hit) begin
            wb_dat_o <= {24'h00_0000, sel_reg_q[idx]};
         end else begin
            wb_dat_o <= 32'h0000_0000;
         end
      end
   end

   // R11 - reset to GPIO, write on lane 0
   generate
      for (genvar r = 0; r < NUM_REGS; r++) begin : g_reg
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               sel_reg_q[r] <= REG_RESET;
            end else if (wr_hit && (idx == 3'(r))) begin
               sel_reg_q[r] <= wb_dat_i[REG_W-1:0];
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // Pin input synchroniser
   // ------------------------------------------------------------
   pfsel_sync #(
      .WIDTH(NUM_PINS)
   ) u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .d_i(pin_in_i),
      .q_o(pin_sync)
   );

   // ------------------------------------------------------------
   // Output routing per pin
   // ------------------------------------------------------------
   logic [NUM_PINS-1:0][3:0] fn_do;
   logic [NUM_PINS-1:0][3:0] fn_oe;

   always_comb begin
      fn_do = '0;
      fn_oe = '0;
      // R6 - chip select on code 10
      fn_do[PIN_PF0][CODE_2] = serial_chip_select_do_i;
      fn_oe[PIN_PF0][CODE_2] = serial_chip_select_oe_i;
      // R5 - serial data out on code 10
      fn_do[PIN_PF1][CODE_2] = serial_data_out_i;
      fn_oe[PIN_PF1][CODE_2] = 1'b1;
      // R4 - bidirectional data on code 10
      fn_do[PIN_PF2][CODE_2] = serial_data_do_i;
      fn_oe[PIN_PF2][CODE_2] = serial_data_oe_i;
      // R3 - serial clock on code 10
      fn_do[PIN_PF3][CODE_2] = serial_clock_do_i;
      fn_oe[PIN_PF3][CODE_2] = serial_clock_oe_i;
      // R9 - periodic timer 0 output
      fn_do[PIN_PF5][CODE_2] = periodic_timer0_out_i;
      fn_oe[PIN_PF5][CODE_2] = 1'b1;
      // R7 - timer 2 output and UART1 transmit
      fn_do[PIN_PF7][CODE_1] = std_timer2_out_i;
      fn_oe[PIN_PF7][CODE_1] = 1'b1;
      fn_do[PIN_PF7][CODE_2] = uart1_transmit_i;
      fn_oe[PIN_PF7][CODE_2] = 1'b1;
      // R10 - UART2 transmit
      fn_do[PIN_PG1][CODE_2] = uart2_transmit_i;
      fn_oe[PIN_PG1][CODE_2] = 1'b1;
      // PF6 code 01 (UART1 receive) leaves fn_oe low: input only
   end

   // R1 - kinds table picks pump or segment
   generate
      for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
         // R11 - field read straight from its register
         assign code[p] = sel_reg_q[PIN_REG[p]][PIN_LSB[p] +: 2];

         pfsel_cell #(
            .KINDS(PIN_KINDS[p])
         ) u_cell (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .code_i(code[p]),
            .gpio_do_i(gpio_do_i[p]),
            .gpio_oe_i(gpio_oe_i[p]),
            .fn_do_i(fn_do[p]),
            .fn_oe_i(fn_oe[p]),
            .pin_do_o(pin_do_o[p]),
            .pin_oe_o(pin_oe_o[p]),
            .pin_ana_o(pin_ana_o[p])
         );
      end
   endgenerate

   // ------------------------------------------------------------
   // Input function decode
   // ------------------------------------------------------------
   // Each flag is high while the pin's field hands it to that input
   // Unrouted inputs sit at their idle level, low except CS and RX
   logic pf0_cs_route;
   logic pf2_sda_route;
   logic pf3_sck_route;
   logic pf5_cap_route;
   logic pf6_clk_route;
   logic pf6_rx_route;
   logic pf7_cap_route;

   // R6 - chip select input on code 10
   assign pf0_cs_route = (code[PIN_PF0] == CODE_2);
   // R4 - serial data input on code 10
   assign pf2_sda_route = (code[PIN_PF2] == CODE_2);
   // R3 - serial clock input on code 10
   assign pf3_sck_route = (code[PIN_PF3] == CODE_2);

   // R9 - capture input on codes 00 and 01
   assign pf5_cap_route = (code[PIN_PF5] == CODE_0)
      || (code[PIN_PF5] == CODE_1);
   // R8 - timer clock on code 00
   assign pf6_clk_route = (code[PIN_PF6] == CODE_0);
   // R8 - UART1 receive on code 01
   assign pf6_rx_route = (code[PIN_PF6] == CODE_1);
   // R7 - capture input on code 00
   assign pf7_cap_route = (code[PIN_PF7] == CODE_0);

   // ------------------------------------------------------------
   // Input routing to peripherals
   // ------------------------------------------------------------
   // Port data reads always see the pin, whatever its function
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         gpio_di_o <= '0;
      end else begin
         gpio_di_o <= pin_sync;
      end
   end

   // R12 - serial clock follows the pin
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         serial_clock_in_o <= 1'b0;
      end else begin
         serial_clock_in_o <= pf3_sck_route && pin_sync[PIN_PF3];
      end
   end

   // R12 - serial data follows the pin
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         serial_data_in_o <= 1'b0;
      end else begin
         serial_data_in_o <= pf2_sda_route && pin_sync[PIN_PF2];
      end
   end

   // R12 - chip select follows the pin
   // Unrouted and in reset it reads inactive (high), so a slave stays idle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         serial_chip_select_in_o <= 1'b1;
      end else begin
         serial_chip_select_in_o <= pf0_cs_route ? pin_sync[PIN_PF0] : 1'b1;
      end
   end

   // R7 - timer 2 capture follows the pin
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         std_timer2_capture_in_o <= 1'b0;
      end else begin
         std_timer2_capture_in_o <= pf7_cap_route && pin_sync[PIN_PF7];
      end
   end

   // R8 - timer 2 clock follows the pin
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         std_timer2_clock_in_o <= 1'b0;
      end else begin
         std_timer2_clock_in_o <= pf6_clk_route && pin_sync[PIN_PF6];
      end
   end

   // R12 - UART1 receive follows the pin
   // Idle-high line when not routed, so no false start bit
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         uart1_receive_o <= 1'b1;
      end else begin
         uart1_receive_o <= pf6_rx_route ? pin_sync[PIN_PF6] : 1'b1;
      end
   end

   // R9 - timer 0 capture follows the pin
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         periodic_timer0_capture_in_o <= 1'b0;
      end else begin
         periodic_timer0_capture_in_o <= pf5_cap_route && pin_sync[PIN_PF5];
      end
   end

endmodule
`default_nettype wire
